// ### hdl/sslp_consts.svh
// Constants for the SRAM sleep-mode controller
`ifndef SSLP_CONSTS_SVH
`define SSLP_CONSTS_SVH
`define SSLP_ENTRY_CYCLES 2
`define SSLP_CLK_PERIOD_PS 4000
`define SSLP_RECOVERY_TIME_NS 100
`define SSLP_RECOVERY_CYCLES ((`SSLP_RECOVERY_TIME_NS * 1000 + `SSLP_CLK_PERIOD_PS - 1) / `SSLP_CLK_PERIOD_PS)
`define SSLP_CNT_W 8
`define SSLP_CMD_RESET 3'h0
`define SSLP_STAT_RESET 3'h2
`endif

// ### hdl/sslp_pkg.sv
// Types for the SRAM sleep-mode controller
package sslp_pkg;
  typedef enum logic [3:0] {
    SSLP_AWAKE   = 4'b0001,
    SSLP_ENTER   = 4'b0010,
    SSLP_SLEEP   = 4'b0100,
    SSLP_RECOVER = 4'b1000
  } sslp_state_t;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
  } sslp_cmd_t;

  typedef struct packed {
    logic asleep;
    logic ready;
    logic recovering;
  } sslp_stat_t;
endpackage

// ### hdl/sslp_recov_timer.sv
// Recovery interval down-counter
`include "sslp_consts.svh"
module sslp_recov_timer (
  input wire logic sys_clk, // Clock
  input wire logic arst_n, // Async reset, active low
  input wire logic start, // Load the count
  input wire logic [`SSLP_CNT_W-1:0] load_val, // Cycles to count
  output logic expired // High when count is zero and start is low
);
  logic [`SSLP_CNT_W-1:0] cnt_q;
  logic [`SSLP_CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == '0) && !start;
endmodule // sslp_recov_timer

// ### hdl/sslp_sleep_ctrl.sv
// Sleep-mode entry, hold and recovery control of a burst SRAM
`include "sslp_consts.svh"
module sslp_sleep_ctrl
  import sslp_pkg::*;
#(
  parameter int unsigned RECOVERY_CYCLES = `SSLP_RECOVERY_CYCLES
) (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic sleep_request, // Sleep request, active high
  input wire sslp_cmd_t cmd_in, // Command from controller
  input wire logic oe_req, // Output enable wanted by datapath
  output sslp_cmd_t cmd_out, // Command passed to the core
  output logic dq_oe, // Data output enable, high drives
  output sslp_stat_t status // Sleep status
);

  ////////////////////////////////////////////////////////////////////
  // State decoding

  // Core is powered down and deselected
  function automatic logic st_asleep(input sslp_state_t st);
    return (st == SSLP_SLEEP);
  endfunction

  // Recovery interval after sleep exit is running
  function automatic logic st_recovering(input sslp_state_t st);
    return (st == SSLP_RECOVER);
  endfunction

  // Commands pass untouched
  function automatic logic st_ready(input sslp_state_t st);
    return (st == SSLP_AWAKE);
  endfunction

  // Command as the core sees it in a given state
  function automatic sslp_cmd_t gate_cmd(input sslp_cmd_t cmd, input sslp_state_t st);
    sslp_cmd_t res;
    res = cmd;
    if (st_asleep(st)) begin
      res = '0;
    end
    // Writes dropped in recovery as a guard; a write here is a controller fault
    if (st_recovering(st)) begin
      res.wr = 1'b0;
    end
    return res;
  endfunction

  // Status word for a given state
  function automatic sslp_stat_t make_stat(input sslp_state_t st);
    sslp_stat_t res;
    res.asleep = st_asleep(st);
    res.ready = st_ready(st);
    res.recovering = st_recovering(st);
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Request sampling

  logic req_q; // Sampled request, one rising edge
  logic req_d;

  // Pin taken as synchronous: setup/hold guaranteed by the controller.
  // One flop only; a request with no timing guarantee would need a synchroniser.
  always_comb begin
    req_d = sleep_request;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sleep state machine

  sslp_state_t state_q;
  sslp_state_t state_d;
  logic timer_start;
  logic timer_expired;

  always_comb begin
    state_d = state_q;
    timer_start = 1'b0;
    unique case (state_q)
      SSLP_AWAKE: begin
        if (req_q) begin
          state_d = SSLP_ENTER;
        end
      end
      SSLP_ENTER: begin
        // Second cycle after the request was seen
        if (req_q) begin
          state_d = SSLP_SLEEP;
        end else begin
          state_d = SSLP_AWAKE;
        end
      end
      SSLP_SLEEP: begin
        // No timeout: leaves only on request low
        if (!req_q) begin
          state_d = SSLP_RECOVER;
          timer_start = 1'b1;
        end
      end
      SSLP_RECOVER: begin
        // Request back high cuts recovery short and restarts entry
        if (req_q) begin
          state_d = SSLP_ENTER;
        end else if (timer_expired) begin
          state_d = SSLP_AWAKE;
        end
      end
      default: state_d = SSLP_AWAKE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SSLP_AWAKE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Recovery timer

  // Loaded on sleep exit; ready waits for it to run out
  sslp_recov_timer u_timer (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .start(timer_start),
    .load_val(`SSLP_CNT_W'(RECOVERY_CYCLES)),
    .expired(timer_expired)
  );

  ////////////////////////////////////////////////////////////////////
  // Command gating

  sslp_cmd_t cmd_d;
  sslp_cmd_t cmd_q;

  // Gated on the next state so deselect and asleep status land on one edge;
  // sleeping ignores inputs and leaves the core's state untouched
  always_comb begin
    cmd_d = gate_cmd(cmd_in, state_d);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= `SSLP_CMD_RESET;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data output enable

  logic oe_d;
  logic oe_q;

  // Drivers float while asleep whatever the datapath asks
  // Registered so the enable moves on the same edge as cmd_out
  always_comb begin
    oe_d = oe_req && !st_asleep(state_d);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status

  sslp_stat_t stat_d;
  sslp_stat_t stat_q;

  // Ready drops on the edge that leaves awake, so a controller polling
  // it never sees ready while entry is under way
  always_comb begin
    stat_d = make_stat(state_d);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= `SSLP_STAT_RESET;
    end else begin
      stat_q <= stat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  // All outputs come straight from flops
  assign cmd_out = cmd_q;
  assign dq_oe = oe_q;
  assign status = stat_q;

endmodule // sslp_sleep_ctrl

// ### testbench/sslp_sleep_ctrl_checker.sv
// Port assertions for the sleep controller
module sslp_sleep_ctrl_checker
  import sslp_pkg::*;
#(
  parameter int RECOVERY_CYCLES = 25
) (
  input wire logic sys_clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic sleep_request, // Sleep request
  input wire sslp_cmd_t cmd_in, // Command in
  input wire logic oe_req, // Oe wish
  input wire sslp_cmd_t cmd_out, // Command out
  input wire logic dq_oe, // Output enable
  input wire sslp_stat_t status // Status
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_sleep_entry: assert property (sleep_request [*3] |=> status.asleep)
    else $error("sleep not entered");
  chk_no_early: assert property ($rose(status.asleep) |-> $past(sleep_request, 3))
    else $error("sleep without request");
  chk_sleep_quiet: assert property (status.asleep |-> cmd_out == '0 && !dq_oe)
    else $error("active while asleep");
  chk_sleep_hold: assert property (sleep_request [*2] ##0 status.asleep |=> status.asleep)
    else $error("sleep ended early");
  chk_wake_recover: assert property ($fell(status.asleep) |-> status.recovering && !status.ready)
    else $error("woke without recovery");
  chk_recov_len: assert property ($rose(status.recovering) |->
    ##RECOVERY_CYCLES status.recovering ##1 status.ready)
    else $error("recovery length wrong");
  chk_recov_nowr: assert property (status.recovering |-> !cmd_out.wr)
    else $error("write during recovery");
  chk_awake_pass: assert property (status.ready && $past(status.ready) |->
    cmd_out == $past(cmd_in) && dq_oe == $past(oe_req))
    else $error("command not passed");
  cover property ($rose(status.asleep));
  cover property ($rose(status.recovering));
  cover property ($fell(status.recovering));
endmodule // sslp_sleep_ctrl_checker
bind sslp_sleep_ctrl sslp_sleep_ctrl_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) i_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .sleep_request(sleep_request), .cmd_in(cmd_in),
  .oe_req(oe_req), .cmd_out(cmd_out), .dq_oe(dq_oe), .status(status));

// ### testbench/sslp_ctrl_model.sv
// Memory controller model facing the sleep controller
module sslp_ctrl_model
  import sslp_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic want_sleep, // Bench asks for sleep
  input wire sslp_cmd_t want_cmd, // Bench command
  input wire logic want_oe, // Bench oe wish
  input wire logic rude, // Let writes through in recovery
  input wire sslp_stat_t status, // Device status
  output sslp_cmd_t cmd_in, // Command to device
  output logic oe_req, // Oe wish to device
  output logic sleep_request // Sleep request
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev_rd = 1'b0;
  initial begin
    cmd_in = '0;
    oe_req = 1'b0;
    sleep_request = 1'b0;
  end
  // Wants sampled on the edge, so bench updates never race the model
  always @(posedge sys_clk) begin
    prev_rd <= want_cmd.rd;
    sleep_request <= #1 want_sleep && (sleep_request || !cmd_in.sel);
    if (want_cmd.wr && prev_rd) begin
      // Dummy read with drivers off before the bus turns to writes
      cmd_in <= #1 3'h6;
      oe_req <= #1 1'b0;
    end else begin
      cmd_in <= #1 want_cmd & {2'b11, rude || !status.recovering};
      oe_req <= #1 want_oe;
    end
  end
endmodule // sslp_ctrl_model

// ### testbench/sslp_sleep_ctrl_bench.sv
// Self-checking bench for the sleep controller
module sslp_sleep_ctrl_bench import sslp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic want_sleep = 1'b0;
  logic want_oe = 1'b0;
  logic rude = 1'b0;
  sslp_cmd_t want_cmd = '0;
  sslp_cmd_t cmd_in, cmd_out;
  logic oe_req, dq_oe, sleep_request;
  sslp_stat_t status;
  int bad_count = 0;
  int total_checks = 0;
  always #2 sys_clk = ~sys_clk;
  sslp_ctrl_model i_sslp_ctrl_model (.sys_clk(sys_clk), .want_sleep(want_sleep),
    .want_cmd(want_cmd), .want_oe(want_oe), .rude(rude), .status(status), .cmd_in(cmd_in),
    .oe_req(oe_req), .sleep_request(sleep_request));
  sslp_sleep_ctrl #(.RECOVERY_CYCLES(3)) i_sslp_sleep_ctrl (.sys_clk(sys_clk),
    .arst_n(arst_n), .sleep_request(sleep_request), .cmd_in(cmd_in), .oe_req(oe_req),
    .cmd_out(cmd_out), .dq_oe(dq_oe), .status(status));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_sleep;
    want_cmd = '0;
    want_oe = 1'b0;
    want_sleep = 1'b1;
    cyc(6);
    chk(status, 3'h4);
    want_cmd = 3'h6;
    want_oe = 1'b1;
    cyc(3);
    chk(cmd_out, 3'h0);
    chk({2'h0, dq_oe}, 3'h0);
  endtask
  task automatic t_wake;
    want_sleep = 1'b0;
    rude = 1'b1;
    want_cmd = 3'h5;
    cyc(3);
    chk(status, 3'h1);
    chk({2'h0, cmd_out.wr}, 3'h0);
    cyc(4);
    chk(status, 3'h2);
    cyc(1);
    chk(cmd_out, 3'h5);
  endtask
  initial begin
    #2000;
    bad_count++;
    finish_test();
  end
  task automatic t_awake;
    want_cmd = 3'h6;
    want_oe = 1'b1;
    cyc(3);
    chk({cmd_out.rd, dq_oe, status.ready}, 3'h7);
  endtask
  task automatic t_abort;
    want_cmd = '0;
    cyc(1);
    want_sleep = 1'b1;
    cyc(1);
    want_sleep = 1'b0;
    cyc(3);
    chk(status, 3'h2);
  endtask
  initial begin
    cyc(20);
    arst_n = 1'b1;
    t_awake();
    t_sleep();
    t_wake();
    t_abort();
    finish_test();
  end
endmodule // sslp_sleep_ctrl_bench
